// ---- src/eea_defines.svh ----
// Overview of operation
// - Control bit 1 permits read operations
// - Bit 0 with permit starts read, stays high for the four read cycles
// - Control bit 3 permits write operations
// - Bit 2 stays high until write completes
// - Write end sets done flag, service clears
// - Data register holds until next operation
// - Address register has five bits, upper zero
`ifndef EEA_DEFINES_SVH
`define EEA_DEFINES_SVH

// Register placement
`define EEA_CTRL_BANK      8'h01
`define EEA_CTRL_OFS       8'h40
`define EEA_DATA_BANK      8'h00
`define EEA_ADDR_OFS       8'h1e
`define EEA_DATA_OFS       8'h1f

// Control field positions
`define EEA_BIT_RD_START   0
`define EEA_BIT_RD_PERMIT  1
`define EEA_BIT_WR_START   2
`define EEA_BIT_WR_PERMIT  3

// Reset values
`define EEA_BYTE_RESET     8'h00
`define EEA_ADDR_RESET     5'h00

// Timing
`define EEA_CLK_PERIOD_NS  50
`define EEA_WRITE_TIME_NS  2000000
`define EEA_READ_CYCLES    3'h4

`endif

// ---- src/eea_pkg.sv ----
package eea_pkg;

  // Access sequencer states, Gray coded
  typedef enum logic [1:0] {
    EEA_IDLE  = 2'b00,
    EEA_READ  = 2'b01,
    EEA_WRITE = 2'b11
  } eea_state_t;

endpackage

// ---- src/eea_write_timer.sv ----
`timescale 1ns/1ps
`include "eea_defines.svh"

// Self-timed write cycle; stands in for the cell's own programming timer
module eea_write_timer #(
  parameter int WRITE_CYCLES = 40000
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // Control
  input  wire logic start_in,
  output logic      done_out
);

  logic [16:0] count;        // Cycles left in the write
  logic [16:0] next_count;
  logic        running;      // Write in progress
  logic        next_running;
  logic        next_done;

  // Next state of the countdown
  always_comb begin
    next_count   = count;
    next_running = running;
    next_done    = 1'b0;
    if (start_in && !running) begin
      // Load full span; a start while running is ignored
      next_count   = 17'(WRITE_CYCLES - 1);
      next_running = 1'b1;
    end else if (running) begin
      if (count == 17'h0) begin
        next_running = 1'b0;
        next_done    = 1'b1;
      end else begin
        next_count = count - 17'h1;
      end
    end
  end

  // Register the countdown
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      count    <= 17'h0;
      running  <= 1'b0;
      done_out <= 1'b0;
    end else begin
      count    <= next_count;
      running  <= next_running;
      done_out <= next_done;
    end
  end

endmodule

// ---- src/eea_top.sv ----
`timescale 1ns/1ps
`include "eea_defines.svh"

// Data EEPROM access control with its 32-byte store
module eea_top
  import eea_pkg::*;
#(
  parameter int WRITE_TIME_NS = `EEA_WRITE_TIME_NS
) (
  // Clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RST_B_IN,
  // Special function register access
  input  wire logic [7:0] BANK_IN,
  input  wire logic [7:0] ADDR_IN,
  input  wire logic       WR_STB_IN,
  input  wire logic [7:0] WDATA_IN,
  output logic      [7:0] RDATA_OUT,
  // Interrupt side
  input  wire logic       DONE_IRQ_EN_IN,
  input  wire logic       DONE_ACK_IN,
  output logic            DONE_FLAG_OUT,
  output logic            IRQ_REQ_OUT
);

  // Minimum write time, rounded up to whole cycles
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + `EEA_CLK_PERIOD_NS - 1) / `EEA_CLK_PERIOD_NS;

  // Register hit decode, shared by all three registers
  function automatic logic reg_hit(input logic [7:0] bank, input logic [7:0] ofs,
                                   input logic [7:0] want_bank, input logic [7:0] want_ofs);
    reg_hit = (bank == want_bank) && (ofs == want_ofs);
  endfunction

  logic [7:0] mem [0:31];       // EEPROM cells
  eea_state_t state;            // Access sequencer
  eea_state_t next_state;
  logic       read_permit;      // Control bit 1
  logic       next_read_permit;
  logic       write_permit;     // Control bit 3
  logic       next_write_permit;
  logic [4:0] eeprom_address_reg;
  logic [4:0] next_address;
  logic [7:0] eeprom_data_reg;
  logic [7:0] next_data;
  logic [4:0] wr_addr;          // Latched target of the write
  logic [4:0] next_wr_addr;
  logic [7:0] wr_data;          // Latched byte of the write
  logic [7:0] next_wr_data;
  logic [2:0] rd_count;         // Read cycle length counter
  logic [2:0] next_rd_count;
  logic       eeprom_done_flag;
  logic       next_done_flag;
  logic [7:0] next_rdata;
  logic       next_irq;
  logic       tmr_start;        // Pulse to the write timer
  logic       tmr_done;         // Write cycle finished
  logic       mem_we;           // Commit latched byte
  logic       sel_ctrl;
  logic       sel_addr;
  logic       sel_data;
  logic [7:0] eeprom_control;   // Readback view of control
  logic       rd_go;
  logic       wr_go;
  logic       read_end;

  // Write timer, clocked by CLK_IN
  eea_write_timer #(
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .start_in (tmr_start),
    .done_out (tmr_done)
  );

  // Decode; control sits only behind bank 1, which guards stray writes
  always_comb begin
    sel_ctrl = reg_hit(BANK_IN, ADDR_IN, `EEA_CTRL_BANK, `EEA_CTRL_OFS);
    sel_addr = reg_hit(BANK_IN, ADDR_IN, `EEA_DATA_BANK, `EEA_ADDR_OFS);
    sel_data = reg_hit(BANK_IN, ADDR_IN, `EEA_DATA_BANK, `EEA_DATA_OFS);
    // Start bits mirror the sequencer, so they read high while busy
    eeprom_control = {4'h0, write_permit, state == EEA_WRITE, read_permit, state == EEA_READ};
  end

  // Next values of control, sequencer and data
  always_comb begin
    next_state        = state;
    next_read_permit  = read_permit;
    next_write_permit = write_permit;
    next_address      = eeprom_address_reg;
    next_data         = eeprom_data_reg;
    next_wr_addr      = wr_addr;
    next_wr_data      = wr_data;
    next_rd_count     = rd_count;
    tmr_start         = 1'b0;
    mem_we            = 1'b0;
    read_end          = 1'b0;
    // Start needs the permit already set; both starts at once is ignored
    rd_go = WR_STB_IN && sel_ctrl && WDATA_IN[`EEA_BIT_RD_START] && !WDATA_IN[`EEA_BIT_WR_START]
            && read_permit && (state == EEA_IDLE);
    wr_go = WR_STB_IN && sel_ctrl && WDATA_IN[`EEA_BIT_WR_START] && !WDATA_IN[`EEA_BIT_RD_START]
            && write_permit && (state == EEA_IDLE);
    if (WR_STB_IN && sel_ctrl) begin
      next_read_permit  = WDATA_IN[`EEA_BIT_RD_PERMIT];
      next_write_permit = WDATA_IN[`EEA_BIT_WR_PERMIT];
    end
    if (WR_STB_IN && sel_addr) begin
      next_address = WDATA_IN[4:0];
    end
    // Software data writes are ignored mid-cycle to keep the result intact
    if (WR_STB_IN && sel_data && (state == EEA_IDLE)) begin
      next_data = WDATA_IN;
    end
    case (state)
      EEA_IDLE: begin
        if (rd_go) begin
          next_state    = EEA_READ;
          next_rd_count = `EEA_READ_CYCLES - 3'h1;
        end else if (wr_go) begin
          next_state   = EEA_WRITE;
          next_wr_addr = eeprom_address_reg;
          next_wr_data = eeprom_data_reg;
          tmr_start    = 1'b1;
        end
      end
      EEA_READ: begin
        if (rd_count == 3'h0) begin
          next_state = EEA_IDLE;
          next_data  = mem[eeprom_address_reg];
          read_end   = 1'b1;
        end else begin
          next_rd_count = rd_count - 3'h1;
        end
      end
      EEA_WRITE: begin
        // Held until the timer reports completion
        if (tmr_done) begin
          next_state = EEA_IDLE;
          mem_we     = 1'b1;
        end
      end
      default: begin
        next_state = EEA_IDLE;
      end
    endcase
    // Completion wins over a same-cycle acknowledge
    next_done_flag = mem_we || (eeprom_done_flag && !DONE_ACK_IN);
    next_irq       = next_done_flag && DONE_IRQ_EN_IN;
    if (sel_ctrl) begin
      next_rdata = eeprom_control;
    end else if (sel_addr) begin
      next_rdata = {3'h0, eeprom_address_reg};
    end else if (sel_data) begin
      next_rdata = eeprom_data_reg;
    end else begin
      next_rdata = `EEA_BYTE_RESET;
    end
  end

  // Register control state and outputs
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      state              <= EEA_IDLE;
      read_permit        <= 1'b0;
      write_permit       <= 1'b0;
      eeprom_address_reg <= `EEA_ADDR_RESET;
      eeprom_data_reg    <= `EEA_BYTE_RESET;
      wr_addr            <= `EEA_ADDR_RESET;
      wr_data            <= `EEA_BYTE_RESET;
      rd_count           <= 3'h0;
      eeprom_done_flag   <= 1'b0;
      DONE_FLAG_OUT      <= 1'b0;
      IRQ_REQ_OUT        <= 1'b0;
      RDATA_OUT          <= `EEA_BYTE_RESET;
    end else begin
      state              <= next_state;
      read_permit        <= next_read_permit;
      write_permit       <= next_write_permit;
      eeprom_address_reg <= next_address;
      eeprom_data_reg    <= next_data;
      wr_addr            <= next_wr_addr;
      wr_data            <= next_wr_data;
      rd_count           <= next_rd_count;
      eeprom_done_flag   <= next_done_flag;
      DONE_FLAG_OUT      <= next_done_flag;
      IRQ_REQ_OUT        <= next_irq;
      RDATA_OUT          <= next_rdata;
    end
  end

  // Cell array; no reset, contents are nonvolatile
  always_ff @(posedge CLK_IN) begin
    if (mem_we) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Checks
  chk_rd_permit_needed: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (WR_STB_IN && sel_ctrl && !read_permit && state == EEA_IDLE) |=> state != EEA_READ)
    else $error("read started without permit");
  chk_rd_start_busy: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    rd_go |=> (eeprom_control[`EEA_BIT_RD_START])[*4] ##1 !eeprom_control[`EEA_BIT_RD_START])
    else $error("read busy bit length wrong");
  chk_wr_permit_needed: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (WR_STB_IN && sel_ctrl && !write_permit && state == EEA_IDLE) |=> state != EEA_WRITE)
    else $error("write started without permit");
  chk_wr_busy_hold: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (state == EEA_WRITE && !tmr_done) |=> eeprom_control[`EEA_BIT_WR_START])
    else $error("write bit dropped early");
  chk_wr_bit_clear: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (state == EEA_WRITE && tmr_done) |=> !eeprom_control[`EEA_BIT_WR_START] && mem[$past(wr_addr)] == $past(wr_data))
    else $error("write end not seen");
  chk_done_flag_set: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (state == EEA_WRITE && tmr_done) |=> DONE_FLAG_OUT
      ##1 (IRQ_REQ_OUT || !$past(DONE_IRQ_EN_IN) || $past(DONE_ACK_IN)))
    else $error("done flag or request missing");
  chk_data_hold: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    !(WR_STB_IN && sel_data) && !read_end |=> $stable(eeprom_data_reg))
    else $error("data register changed unasked");
  chk_addr_upper_zero: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    sel_addr |=> RDATA_OUT[7:5] == 3'h0)
    else $error("address upper bits not zero");

endmodule

// ---- tb/eea_top_tb_top.sv ----
`timescale 1ns/1ps
`include "eea_defines.svh"

// Self-checking bench for the EEPROM access control
module eea_top_tb_top;
  logic       clk;          // System clock
  logic       rst_b;        // Synchronous reset, active low
  logic [7:0] bank;         // Bank of the access
  logic [7:0] addr;         // Offset of the access
  logic       wr_stb;       // Write strobe
  logic [7:0] wdata;        // Write data
  logic [7:0] rdata;        // Registered readback
  logic       irq_en;       // Done interrupt enable
  logic       ack;          // Interrupt serviced
  logic       flag;         // Sticky done flag
  logic       irq;          // Interrupt request
  int         err_count;    // Mismatches seen
  int         comparisons;  // Checks made
  int         cycles;       // Watchdog count

  // Short write time keeps the run brief: 10 cycles
  eea_top #(.WRITE_TIME_NS(500)) dut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .BANK_IN(bank), .ADDR_IN(addr),
    .WR_STB_IN(wr_stb), .WDATA_IN(wdata), .RDATA_OUT(rdata),
    .DONE_IRQ_EN_IN(irq_en), .DONE_ACK_IN(ack), .DONE_FLAG_OUT(flag), .IRQ_REQ_OUT(irq)
  );

  // Free-running clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Byte comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Flag comparison
  task automatic chkb(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single register write, one idle cycle after
  task automatic wr(input logic [7:0] b, input logic [7:0] o, input logic [7:0] d);
    bank = b;
    addr = o;
    wdata = d;
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    @(negedge clk);
  endtask

  // Permit then start in consecutive cycles, then one idle cycle
  task automatic start(input logic [7:0] d1, input logic [7:0] d2);
    bank = `EEA_CTRL_BANK;
    addr = `EEA_CTRL_OFS;
    wdata = d1;
    wr_stb = 1'b1;
    @(negedge clk);
    wdata = d2;
    @(negedge clk);
    wr_stb = 1'b0;
    @(negedge clk);
  endtask

  // Register read: readback lands one edge after the address
  task automatic rd(input logic [7:0] b, input logic [7:0] o, input logic [7:0] exp);
    bank = b;
    addr = o;
    @(negedge clk);
    chk(rdata, exp);
  endtask

  // Poll a control busy bit low, bounded
  task automatic poll(input int bitn);
    int n;
    bank = `EEA_CTRL_BANK;
    addr = `EEA_CTRL_OFS;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (rdata[bitn] === 1'b0) break;
    end
    chkb(rdata[bitn], 1'b0);
  endtask

  // Hang guard, far beyond the expected hundred or so cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    bank = 8'h00;
    addr = 8'h00;
    wr_stb = 1'b0;
    wdata = 8'h00;
    irq_en = 1'b0;
    ack = 1'b0;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    // Reset state and unmapped place
    rd(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h00);
    rd(`EEA_DATA_BANK, `EEA_ADDR_OFS, 8'h00);
    rd(`EEA_DATA_BANK, `EEA_DATA_OFS, 8'h00);
    rd(8'h00, 8'h55, 8'h00);
    chkb(flag, 1'b0);
    chkb(irq, 1'b0);
    // Address register keeps five bits only
    wr(`EEA_DATA_BANK, `EEA_ADDR_OFS, 8'hff);
    rd(`EEA_DATA_BANK, `EEA_ADDR_OFS, 8'h1f);
    // Starts without permit are refused
    wr(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h04);
    rd(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h00);
    wr(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h01);
    rd(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h00);
    wr(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h0c);
    rd(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h08);
    // Two writes, flag and interrupt handling
    wr(`EEA_DATA_BANK, `EEA_ADDR_OFS, 8'h05);
    wr(`EEA_DATA_BANK, `EEA_DATA_OFS, 8'ha5);
    start(8'h08, 8'h0c);
    rd(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h0c);
    chkb(flag, 1'b0);
    poll(`EEA_BIT_WR_START);
    chkb(flag, 1'b1);
    chkb(irq, 1'b0);
    irq_en = 1'b1;
    repeat (2) @(negedge clk);
    chkb(irq, 1'b1);
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    @(negedge clk);
    chkb(flag, 1'b0);
    chkb(irq, 1'b0);
    wr(`EEA_DATA_BANK, `EEA_ADDR_OFS, 8'h06);
    wr(`EEA_DATA_BANK, `EEA_DATA_OFS, 8'h3c);
    // Interrupts masked only around the start, as software must
    irq_en = 1'b0;
    start(8'h08, 8'h0c);
    irq_en = 1'b1;
    poll(`EEA_BIT_WR_START);
    chkb(flag, 1'b1);
    chkb(irq, 1'b1);
    wr(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h00);
    // Read both cells back
    wr(`EEA_DATA_BANK, `EEA_ADDR_OFS, 8'h05);
    start(8'h02, 8'h03);
    rd(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h03);
    poll(`EEA_BIT_RD_START);
    rd(`EEA_DATA_BANK, `EEA_DATA_OFS, 8'ha5);
    wr(`EEA_DATA_BANK, `EEA_ADDR_OFS, 8'h06);
    wr(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h03);
    poll(`EEA_BIT_RD_START);
    rd(`EEA_DATA_BANK, `EEA_DATA_OFS, 8'h3c);
    // Data survives clearing the control register
    wr(`EEA_CTRL_BANK, `EEA_CTRL_OFS, 8'h00);
    repeat (5) @(negedge clk);
    rd(`EEA_DATA_BANK, `EEA_DATA_OFS, 8'h3c);
    stop_test();
  end
endmodule
